// ### src/bdp_pkg.sv
// shared constants of the burst-of-four ddr static memory link
package bdp_pkg;
  // ****************************************************************
  // organisation
  // ****************************************************************
  localparam int DATA_W = 36;
  localparam int ADDR_W = 19;
  localparam int BEATS  = 4;
  localparam int BYTE_W = 9;
  // ****************************************************************
  // controller link clock divider in clk_in cycles, read busy period in link periods, write beat phases
  // ****************************************************************
  localparam logic [2:0] CNT_RISE    = 3'h0;
  localparam logic [2:0] CNT_KN_DAT  = 3'h2;
  localparam logic [2:0] CNT_READY   = 3'h3;
  localparam logic [2:0] CNT_FALL    = 3'h4;
  localparam logic [2:0] CNT_K_DAT   = 3'h6;
  localparam logic [2:0] CNT_RST     = 3'h7;
  localparam logic [3:0] RD_BUSY_PER = 4'h7;
  localparam logic [2:0] WPH_IDLE    = 3'h0;
  localparam logic [2:0] WPH_B2      = 3'h2;
  localparam logic [2:0] WPH_B3      = 3'h3;
  localparam logic [2:0] WPH_B4      = 3'h4;
  // ****************************************************************
  // read data buffer
  // ****************************************************************
  localparam int FIFO_DEPTH = 32;
endpackage

// ### src/bdp_link_if.sv
// link wires between the memory controller and the ddr static memory
`timescale 1ns/1ps
interface bdp_link_if #(
  parameter int W  = bdp_pkg::DATA_W,
  parameter int AW = bdp_pkg::ADDR_W,
  parameter int NB = bdp_pkg::DATA_W / bdp_pkg::BYTE_W
);
  logic          k;
  logic          k_n;
  logic [AW-1:0] addr_in;
  logic          rd_n;
  logic          wr_n;
  logic [W-1:0]  d;
  logic [NB-1:0] byte_we_n;
  logic          dll_off_n;
  logic [W-1:0]  q;
  logic          echo_pos;
  logic          echo_neg;
  logic          read_valid_out;

  modport ctrl (
    output k, k_n, addr_in, rd_n, wr_n, d, byte_we_n, dll_off_n,
    input  q, echo_pos, echo_neg, read_valid_out
  );
  modport mem (
    input  k, k_n, addr_in, rd_n, wr_n, d, byte_we_n, dll_off_n,
    output q, echo_pos, echo_neg, read_valid_out
  );
endinterface

// ### src/bdp_fifo.sv
// read data buffer with valid and ready on both sides
`timescale 1ns/1ps
module bdp_fifo #(
  parameter int W     = bdp_pkg::DATA_W,
  parameter int DEPTH = bdp_pkg::FIFO_DEPTH,
  parameter int PW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // fill side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // drain side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out,
  output logic [PW:0]       level_out
);
  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0]   count;
  } bdp_fst_t;

  bdp_fst_t     r;
  bdp_fst_t     n;
  logic [W-1:0] buf_q [0:DEPTH-1];
  logic         push;
  logic         pop;

  always_comb begin
    n      = r;
    push   = in_valid_in && (r.count != (PW+1)'(DEPTH));
    pop    = out_ready_in && (r.count != '0);
    n.wptr = r.wptr + PW'(push);
    n.rptr = r.rptr + PW'(pop);
    n.count = r.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      buf_q[r.wptr] <= in_data_in;
    end
  end

  assign in_ready_out  = r.count != (PW+1)'(DEPTH);
  assign out_valid_out = r.count != '0;
  assign out_data_out  = buf_q[r.rptr];
  assign level_out     = r.count;
endmodule // bdp_fifo

// ### src/bdp_ctrl.sv
// memory controller end: makes the link clock, issues bursts, buffers reads
`timescale 1ns/1ps
module bdp_ctrl
  import bdp_pkg::*;
#(
  parameter int W  = bdp_pkg::DATA_W,
  parameter int AW = bdp_pkg::ADDR_W,
  parameter int NB = bdp_pkg::DATA_W / bdp_pkg::BYTE_W
) (
  // clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         nrst_in,
  // link to the memory
  bdp_link_if.ctrl                          link,
  // mode and clock stop
  input  wire logic                         bypass_in,
  input  wire logic                         stop_in,
  // write requests
  input  wire logic                         wr_valid_in,
  output logic                              wr_ready_out,
  input  wire logic [AW-1:0]                wr_addr_in,
  input  wire logic [bdp_pkg::BEATS*W-1:0]  wr_data_in,
  input  wire logic [bdp_pkg::BEATS*NB-1:0] wr_be_in,
  // read requests
  input  wire logic                         rd_valid_in,
  output logic                              rd_ready_out,
  input  wire logic [AW-1:0]                rd_addr_in,
  // read data
  output logic                              rdata_valid_out,
  input  wire logic                         rdata_ready_in,
  output logic [W-1:0]                      rdata_out
);
  import bdp_pkg::*;
  localparam int PW = $clog2(FIFO_DEPTH);

  typedef struct packed {
    logic [2:0]          cnt;
    logic                k;
    logic                kn;
    logic                slot;
    logic                dll_off_n;
    logic [AW-1:0]       addr;
    logic                rd_n;
    logic                wr_n;
    logic [W-1:0]        d;
    logic [NB-1:0]       be_n;
    logic                rd_rdy;
    logic                wr_rdy;
    logic                wpend;
    logic [BEATS*W-1:0]  wnx_d;
    logic [BEATS*NB-1:0] wnx_be;
    logic [BEATS*W-1:0]  wcur_d;
    logic [BEATS*NB-1:0] wcur_be;
    logic [2:0]          wph;
    logic [3:0]          busy;
    logic [PW:0]         owe;
    logic [3:0]          echo_s;
    logic [1:0]          vld_s;
    logic [W-1:0]        q_s1;
    logic [W-1:0]        q_s2;
    logic                push;
    logic [W-1:0]        pdat;
  } bdp_cst_t;

  bdp_cst_t    r;
  bdp_cst_t    n;
  logic        idle;
  logic        run;
  logic [2:0]  cnt_n;
  logic        fifo_rdy;
  logic [PW:0] level;

  function automatic logic [W-1:0] bdp_beat(input logic [BEATS*W-1:0] v, input int i);
    return v[i*W +: W];
  endfunction

  function automatic logic [NB-1:0] bdp_bes(input logic [BEATS*NB-1:0] v, input int i);
    return ~v[i*NB +: NB];
  endfunction

  // ****************************************************************
  // divider, command slots, write beats, read capture
  // ****************************************************************
  always_comb begin
    n        = r;
    idle     = r.rd_n && r.wr_n && !r.wpend && r.wph == WPH_IDLE && r.busy == 4'h0;
    run      = !(stop_in && idle && r.cnt == CNT_FALL);
    cnt_n    = run ? r.cnt + 3'h1 : r.cnt;
    n.cnt    = cnt_n;
    n.k      = cnt_n < CNT_FALL;
    n.kn     = !(cnt_n < CNT_FALL);
    n.dll_off_n = !bypass_in;
    n.rd_rdy = 1'b0;
    n.wr_rdy = 1'b0;
    n.echo_s = {r.echo_s[2:0], link.echo_pos};
    n.vld_s  = {r.vld_s[0], link.read_valid_out};
    n.q_s1   = link.q;
    n.q_s2   = r.q_s1;
    // strobe on a settled echo edge, data one stage behind it
    n.push   = (r.echo_s[2] ^ r.echo_s[3]) && r.vld_s[1];
    n.pdat   = r.q_s2;
    n.owe    = r.owe - (PW+1)'(r.push);
    if (run) begin
      case (cnt_n)
        CNT_RISE: begin
          n.slot = !r.slot;
          if (r.busy != 4'h0) begin
            n.busy = r.busy - 4'h1;
          end
        end
        CNT_KN_DAT: begin
          if (r.wph == WPH_B2) begin
            n.d    = bdp_beat(r.wcur_d, 1);
            n.be_n = bdp_bes(r.wcur_be, 1);
            n.wph  = WPH_B3;
          end else if (r.wph == WPH_B4) begin
            n.d    = bdp_beat(r.wcur_d, 3);
            n.be_n = bdp_bes(r.wcur_be, 3);
            n.wph  = WPH_IDLE;
          end
        end
        CNT_READY: begin
          if (!stop_in) begin
            n.rd_rdy = r.slot && fifo_rdy &&
                       ({1'b0, level} + {1'b0, r.owe} + (PW+2)'(BEATS)
                        <= (PW+2)'(FIFO_DEPTH));
            n.wr_rdy = !r.slot && !r.wpend;
          end
        end
        CNT_FALL: begin
          n.rd_n = 1'b1;
          n.wr_n = 1'b1;
          if (r.rd_rdy && rd_valid_in) begin
            n.rd_n = 1'b0;
            n.addr = rd_addr_in;
            n.busy = RD_BUSY_PER;
            n.owe  = n.owe + (PW+1)'(BEATS);
          end
          if (r.wr_rdy && wr_valid_in) begin
            n.wr_n   = 1'b0;
            n.addr   = wr_addr_in;
            n.wpend  = 1'b1;
            n.wnx_d  = wr_data_in;
            n.wnx_be = wr_be_in;
          end
        end
        CNT_K_DAT: begin
          if (r.wph == WPH_B3) begin
            n.d    = bdp_beat(r.wcur_d, 2);
            n.be_n = bdp_bes(r.wcur_be, 2);
            n.wph  = WPH_B4;
          // first beat waits until the command's k rise has gone by
          end else if (r.wpend && r.wr_n) begin
            n.d       = bdp_beat(r.wnx_d, 0);
            n.be_n    = bdp_bes(r.wnx_be, 0);
            n.wcur_d  = r.wnx_d;
            n.wcur_be = r.wnx_be;
            n.wph     = WPH_B2;
            n.wpend   = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // start one step before a rise so the first k high phase is full length
      r <= '{cnt: CNT_RST, rd_n: 1'b1, wr_n: 1'b1, be_n: '1, dll_off_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  bdp_fifo #(
    .W     (W),
    .DEPTH (FIFO_DEPTH)
  ) u_rfifo (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (r.push),
    .in_ready_out  (fifo_rdy),
    .in_data_in    (r.pdat),
    .out_valid_out (rdata_valid_out),
    .out_ready_in  (rdata_ready_in),
    .out_data_out  (rdata_out),
    .level_out     (level)
  );

  assign link.k         = r.k;
  assign link.k_n       = r.kn;
  assign link.addr_in   = r.addr;
  assign link.rd_n      = r.rd_n;
  assign link.wr_n      = r.wr_n;
  assign link.d         = r.d;
  assign link.byte_we_n = r.be_n;
  assign link.dll_off_n = r.dll_off_n;
  assign wr_ready_out   = r.wr_rdy;
  assign rd_ready_out   = r.rd_rdy;
endmodule // bdp_ctrl

// ### src/bdp_sram.sv
// memory end: burst-of-four ddr static memory with separate ports
`timescale 1ns/1ps
// What this block does
// - separate read and write ports, concurrently active
// - 2M x 36 or 4M x 18 by parameters
// - every burst is exactly four beats
// - addresses alternate read and write rising edges
// - address and selects sampled on k rise only
// - write beats one, three on k; two, four on k_n
// - per-beat byte enables; disabled bytes stay unchanged
// - controller sends first beat one cycle after command
// - write buffer commits the late-arriving write data
// - each write takes two full clock cycles
// - read beats out 2.5 cycles after command
// - each read takes two cycles, data ddr
// - echo clocks edge-aligned with read data
// - read valid marks data beats, echo aligned
// - echo clocks keep running while data idle
// - loop disabled means one-cycle read latency
// - address ignored on edges with no select
module bdp_sram
  import bdp_pkg::*;
#(
  parameter int W  = bdp_pkg::DATA_W,
  parameter int AW = bdp_pkg::ADDR_W
) (
  // link from the controller
  bdp_link_if.mem   link,
  // reset
  input  wire logic nrst_in
);
  import bdp_pkg::*;
  localparam int NB = W / BYTE_W;
  localparam int MW = AW + 2;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef logic [BEATS-1:0][W-1:0]  bdp_burst_t;
  typedef logic [BEATS-1:0][NB-1:0] bdp_bmask_t;

  // state on the rising edge of k
  typedef struct packed {
    logic          tk;
    logic [1:0]    byp_s;
    logic [3:0]    rs;
    logic [AW-1:0] raddr;
    bdp_burst_t    rbuf;
    logic [2:0]    ws;
    logic [AW-1:0] waddr;
    logic [AW-1:0] caddr;
    logic [W-1:0]  wd1;
    logic [W-1:0]  wd3;
    logic [NB-1:0] be1_n;
    logic [NB-1:0] be3_n;
    logic [W-1:0]  qk;
    logic          vk;
  } bdp_kst_t;

  // state on the rising edge of k_n
  typedef struct packed {
    logic          tn;
    logic [W-1:0]  wd2;
    logic [W-1:0]  wd4;
    logic [NB-1:0] be2_n;
    logic [NB-1:0] be4_n;
    logic [W-1:0]  qn;
    logic          vn;
  } bdp_nst_t;

  bdp_kst_t   k_r;
  bdp_kst_t   k_nxt;
  bdp_nst_t   n_r;
  bdp_nst_t   n_nxt;
  logic [W-1:0] mem_q [0:(1<<MW)-1];
  bdp_burst_t wr_burst;
  bdp_bmask_t wr_be_n;
  bdp_burst_t rd_burst;
  logic       bypass;
  logic       rd_take;
  logic       wr_take;
  logic       commit;
  logic       ph;

  // only bytes whose enable is low take the new value
  function automatic logic [W-1:0] bdp_merge(input logic [W-1:0]  old_w,
                                             input logic [W-1:0]  new_w,
                                             input logic [NB-1:0] en_n);
    logic [W-1:0] res;
    res = old_w;
    for (int i = 0; i < NB; i++) begin
      if (!en_n[i]) begin
        res[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // write buffer and array read with forwarding
  // ****************************************************************
  always_comb begin
    commit   = k_r.ws[2];
    wr_burst = {n_r.wd4, k_r.wd3, n_r.wd2, k_r.wd1};
    wr_be_n  = {n_r.be4_n, k_r.be3_n, n_r.be2_n, k_r.be1_n};
    for (int b = 0; b < BEATS; b++) begin
      rd_burst[b] = mem_q[{k_r.raddr, 2'(b)}];
      if (commit && k_r.caddr == k_r.raddr) begin
        rd_burst[b] = bdp_merge(rd_burst[b], wr_burst[b], wr_be_n[b]);
      end
    end
  end

  assign bypass = k_r.byp_s[1];

  // ****************************************************************
  // rising edge of k: commands, odd write beats, even read beats (odd read beats in bypass)
  // ****************************************************************
  always_comb begin
    k_nxt       = k_r;
    rd_take     = !link.rd_n;
    wr_take     = !link.wr_n;
    k_nxt.tk    = !k_r.tk;
    k_nxt.byp_s = {k_r.byp_s[0], !link.dll_off_n};
    // both ports advance on the same edge, independently
    k_nxt.rs    = {k_r.rs[2:0], rd_take};
    k_nxt.ws    = {k_r.ws[1:0], wr_take};
    if (rd_take) begin
      k_nxt.raddr = link.addr_in;
    end
    if (wr_take) begin
      k_nxt.waddr = link.addr_in;
    end
    if (k_r.ws[0]) begin
      k_nxt.wd1   = link.d;
      k_nxt.be1_n = link.byte_we_n;
    end
    if (k_r.ws[1]) begin
      k_nxt.wd3   = link.d;
      k_nxt.be3_n = link.byte_we_n;
      k_nxt.caddr = k_r.waddr;
    end
    if (bypass ? k_r.rs[0] : k_r.rs[1]) begin
      k_nxt.rbuf = rd_burst;
    end
    k_nxt.vk = 1'b0;
    if (bypass) begin
      if (k_r.rs[0]) begin
        k_nxt.qk = rd_burst[0];
        k_nxt.vk = 1'b1;
      end else if (k_r.rs[1]) begin
        k_nxt.qk = k_r.rbuf[2];
        k_nxt.vk = 1'b1;
      end
    end else begin
      if (k_r.rs[2]) begin
        k_nxt.qk = k_r.rbuf[1];
        k_nxt.vk = 1'b1;
      end else if (k_r.rs[3]) begin
        k_nxt.qk = k_r.rbuf[3];
        k_nxt.vk = 1'b1;
      end
    end
  end

  // ****************************************************************
  // rising edge of k_n: even write beats, odd read beats (even read beats in bypass)
  // ****************************************************************
  // k_n is the complement of k, so k state seen here is half a cycle old
  always_comb begin
    n_nxt    = n_r;
    n_nxt.tn = !n_r.tn;
    if (k_r.ws[1]) begin
      n_nxt.wd2   = link.d;
      n_nxt.be2_n = link.byte_we_n;
    end
    if (k_r.ws[2]) begin
      n_nxt.wd4   = link.d;
      n_nxt.be4_n = link.byte_we_n;
    end
    n_nxt.vn = 1'b0;
    if (bypass) begin
      if (k_r.rs[1]) begin
        n_nxt.qn = k_r.rbuf[1];
        n_nxt.vn = 1'b1;
      end else if (k_r.rs[2]) begin
        n_nxt.qn = k_r.rbuf[3];
        n_nxt.vn = 1'b1;
      end
    end else begin
      if (k_r.rs[2]) begin
        n_nxt.qn = k_r.rbuf[0];
        n_nxt.vn = 1'b1;
      end else if (k_r.rs[3]) begin
        n_nxt.qn = k_r.rbuf[2];
        n_nxt.vn = 1'b1;
      end
    end
  end

  // ****************************************************************
  // registers and array
  // ****************************************************************
  always_ff @(posedge link.k or negedge nrst_in) begin
    if (!nrst_in) begin
      k_r <= '0;
    end else begin
      k_r <= k_nxt;
    end
  end

  always_ff @(posedge link.k_n or negedge nrst_in) begin
    if (!nrst_in) begin
      n_r <= '0;
    end else begin
      n_r <= n_nxt;
    end
  end

  always_ff @(posedge link.k) begin
    if (commit) begin
      for (int b = 0; b < BEATS; b++) begin
        mem_q[{k_r.caddr, 2'(b)}] <= bdp_merge(mem_q[{k_r.caddr, 2'(b)}],
                                               wr_burst[b], wr_be_n[b]);
      end
    end
  end

  // ****************************************************************
  // ddr outputs
  // ****************************************************************
  // ph is high after a k edge and low after a k_n edge
  assign ph                  = k_r.tk ^ n_r.tn;
  assign link.q              = ph ? k_r.qk : n_r.qn;
  assign link.read_valid_out = ph ? k_r.vk : n_r.vn;
  assign link.echo_pos       = ph;
  assign link.echo_neg       = !ph;
endmodule // bdp_sram

// ### verification/bdp_link_props.sv
// link checker: timing relations on the wires between the two ends
`timescale 1ns/1ps
module bdp_link_props
  import bdp_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // link wires
  input  wire logic k,
  input  wire logic k_n,
  input  wire logic rd_n,
  input  wire logic wr_n,
  input  wire logic dll_off_n,
  input  wire logic echo_pos,
  input  wire logic echo_neg,
  input  wire logic read_valid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence rd_cmd;
    $fell(rd_n) && dll_off_n;
  endsequence
  sequence rd_cmd_byp;
    $fell(rd_n) && !dll_off_n;
  endsequence
  sequence rd_beats;
    read_valid_out [*4];
  endsequence
  sequence k_phase;
    k [*4] ##1 !k;
  endsequence

  // ****************************************************************
  // properties
  // ****************************************************************
  AST_K_HIGH: assert property ($rose(k) |-> k_phase)
    else $error("link clock high phase is not four cycles");
  AST_K_PAIR: assert property (!(k && k_n))
    else $error("link clock pair high together");
  AST_RW_ALT: assert property (!(!rd_n && !wr_n))
    else $error("read and write selected together");
  AST_WR_LEN: assert property ($fell(wr_n) |-> !wr_n [*8] ##1 wr_n)
    else $error("write select not one link period");
  AST_WR_GAP: assert property ($fell(wr_n) |-> ##8 wr_n [*8])
    else $error("writes closer than two link periods");
  AST_RD_GAP: assert property ($fell(rd_n) |-> !rd_n [*8] ##1 rd_n [*8])
    else $error("read select length or spacing wrong");
  AST_RD_LAT: assert property (rd_cmd |-> ##[22:26] rd_beats)
    else $error("read data not valid 2.5 periods after command");
  AST_RD_LAT_BYP: assert property (rd_cmd_byp |-> ##[10:14] rd_beats)
    else $error("read data not valid one period after command in bypass");
  AST_ECHO_PAIR: assert property (echo_neg == !echo_pos)
    else $error("echo clocks not complementary");
  AST_ECHO_RUN: assert property ($rose(k) |-> ##[0:2] echo_pos)
    else $error("echo clock did not follow link clock");
  AST_VALID_ALIGN: assert property ($changed(read_valid_out) |-> $changed(echo_pos))
    else $error("read valid moved off an echo edge");
endmodule // bdp_link_props

// ### verification/tb_burst4_ddr_sram_port.sv
// self-checking bench: controller and memory joined over the link
`timescale 1ns/1ps
module tb_burst4_ddr_sram_port;
  import bdp_pkg::*;
  localparam int NB    = DATA_W / BYTE_W;
  localparam int LIMIT = 40000;
  logic                   clk_in, nrst_in, bypass_in, stop_in;
  logic                   wr_valid_in, wr_ready_out, rd_valid_in, rd_ready_out;
  logic                   rdata_valid_out, rdata_ready_in;
  logic [ADDR_W-1:0]      wr_addr_in, rd_addr_in;
  logic [BEATS*DATA_W-1:0] wr_data_in;
  logic [BEATS*NB-1:0]    wr_be_in;
  logic [DATA_W-1:0]      rdata_out;
  logic [BEATS*DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0]      exp_q [$];
  logic [ADDR_W-1:0]      adr [6];
  int                     n_fail, cmp_count, cyc;
  bit                     t, stall, kv;

  bdp_link_if u_bdp_link_if ();
  bdp_ctrl u_bdp_ctrl (.clk_in(clk_in), .nrst_in(nrst_in), .link(u_bdp_link_if),
    .bypass_in(bypass_in), .stop_in(stop_in), .wr_valid_in(wr_valid_in),
    .wr_ready_out(wr_ready_out), .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in),
    .wr_be_in(wr_be_in), .rd_valid_in(rd_valid_in), .rd_ready_out(rd_ready_out),
    .rd_addr_in(rd_addr_in), .rdata_valid_out(rdata_valid_out),
    .rdata_ready_in(rdata_ready_in), .rdata_out(rdata_out));
  bdp_sram u_bdp_sram (.link(u_bdp_link_if), .nrst_in(nrst_in));
  bdp_link_props u_bdp_link_props (.clk_in(clk_in), .nrst_in(nrst_in),
    .k(u_bdp_link_if.k), .k_n(u_bdp_link_if.k_n), .rd_n(u_bdp_link_if.rd_n),
    .wr_n(u_bdp_link_if.wr_n), .dll_off_n(u_bdp_link_if.dll_off_n),
    .echo_pos(u_bdp_link_if.echo_pos), .echo_neg(u_bdp_link_if.echo_neg),
    .read_valid_out(u_bdp_link_if.read_valid_out));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    cmp_count++;
    if (g !== e || $isunknown(g)) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // write burst; the model merges only enabled bytes once taken
  task automatic do_write(input logic [ADDR_W-1:0] a, input bit full, input int lim,
                          output bit taken);
    logic [BEATS*DATA_W-1:0] d, old;
    logic [BEATS*NB-1:0]     be;
    d = (BEATS*DATA_W)'({$urandom, $urandom, $urandom, $urandom, $urandom});
    be = full ? '1 : (BEATS*NB)'($urandom);
    taken = 0;
    @(posedge clk_in);
    #1 wr_valid_in = 1;
    wr_addr_in = a;
    wr_data_in = d;
    wr_be_in = be;
    for (int i = 0; i < lim && !taken; i++) begin
      @(posedge clk_in);
      taken = (wr_ready_out === 1'b1);
    end
    #1 wr_valid_in = 0;
    if (taken) begin
      old = mem.exists(a) ? mem[a] : '0;
      for (int b = 0; b < BEATS*NB; b++)
        if (be[b]) old[b*BYTE_W +: BYTE_W] = d[b*BYTE_W +: BYTE_W];
      mem[a] = old;
    end
  endtask

  task automatic do_read(input logic [ADDR_W-1:0] a, input int lim, output bit taken);
    taken = 0;
    @(posedge clk_in);
    #1 rd_valid_in = 1;
    rd_addr_in = a;
    for (int i = 0; i < lim && !taken; i++) begin
      @(posedge clk_in);
      taken = (rd_ready_out === 1'b1);
    end
    #1 rd_valid_in = 0;
    if (taken)
      for (int b = 0; b < BEATS; b++) exp_q.push_back(mem[a][b*DATA_W +: DATA_W]);
  endtask

  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clk_in);
    chk("beats_left", '0, DATA_W'(exp_q.size()));
  endtask

  // ****************************************************************
  // clock, drain side, result compare, timeout
  // ****************************************************************
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    rdata_ready_in = 0;
    forever begin
      @(posedge clk_in);
      #1 rdata_ready_in = !stall && ($urandom % 4 != 0);
    end
  end

  always @(posedge clk_in) begin
    if (rdata_valid_out === 1'b1 && rdata_ready_in) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("MISMATCH rdata expected none seen %h", rdata_out);
      end else begin
        chk("rdata", exp_q.pop_front(), rdata_out);
      end
    end
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc >= LIMIT) begin
      n_fail++;
      close_out();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    nrst_in = 0;
    bypass_in = 0;
    stop_in = 0;
    wr_valid_in = 0;
    rd_valid_in = 0;
    wr_addr_in = '0;
    wr_data_in = '0;
    wr_be_in = '0;
    rd_addr_in = '0;
    stall = 0;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(32'h3e848602));
    for (int i = 2; i < 6; i++) adr[i] = ADDR_W'($urandom);
    adr[0] = '0;
    adr[1] = '1;
    repeat (16) @(posedge clk_in);
    #1 nrst_in = 1;
    for (int i = 0; i < 30; i++) begin
      do_write(adr[i%6], i < 6, 40, t);
      chk("wr_taken", DATA_W'(1), DATA_W'(t));
      do_read(adr[i < 6 ? i : (i*5)%6], 40, t);
      chk("rd_taken", DATA_W'(1), DATA_W'(t));
    end
    drain();
    #1 stop_in = 1;
    repeat (20) @(posedge clk_in);
    do_write(adr[2], 0, 64, t);
    chk("stop_refused", '0, DATA_W'(t));
    kv = u_bdp_link_if.k;
    repeat (4) @(posedge clk_in);
    #1 chk("k_frozen", DATA_W'(kv), DATA_W'(u_bdp_link_if.k));
    stop_in = 0;
    do_write(adr[2], 0, 64, t);
    chk("resume_wr", DATA_W'(1), DATA_W'(t));
    do_read(adr[2], 40, t);
    chk("resume_rd", DATA_W'(1), DATA_W'(t));
    drain();
    stall = 1;
    for (int i = 0; i < 8; i++) begin
      do_read(adr[i%6], 40, t);
      chk("fill", DATA_W'(1), DATA_W'(t));
    end
    do_read(adr[0], 64, t);
    chk("full_refused", '0, DATA_W'(t));
    chk("full_valid", DATA_W'(1), DATA_W'(rdata_valid_out));
    stall = 0;
    drain();
    #1 bypass_in = 1;
    repeat (100) @(posedge clk_in);
    for (int i = 0; i < 6; i++) begin
      do_write(adr[i], 0, 40, t);
      chk("byp_wr", DATA_W'(1), DATA_W'(t));
      repeat (40) @(posedge clk_in);
      do_read(adr[i], 40, t);
      chk("byp_rd", DATA_W'(1), DATA_W'(t));
    end
    drain();
    #1 bypass_in = 0;
    close_out();
  end
endmodule // tb_burst4_ddr_sram_port
